// *** tcm_top.sv ***
// capture/compare mode control for timer channels 1 and 2 with wishbone slave
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tcm_top (
   input  wire logic        clk,                        // timer kernel clock
   input  wire logic        rst,                        // synchronous reset, active high
   input  wire logic        wb_cyc_i,                   // wishbone cycle
   input  wire logic        wb_stb_i,                   // wishbone strobe
   input  wire logic        wb_we_i,                    // wishbone write enable
   input  wire logic [7:0]  wb_adr_i,                   // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,                   // wishbone byte lanes
   input  wire logic [31:0] wb_dat_i,                   // wishbone write data
   output var  logic [31:0] wb_dat_o,                   // wishbone read data
   output var  logic        wb_ack_o,                   // wishbone acknowledge
   input  wire logic        timer_input_one,            // channel 1 pin input
   input  wire logic        timer_input_two,            // channel 2 pin input
   input  wire logic        internal_trigger_source,    // internal trigger level
   input  wire logic        trigger_source_internal,    // internal trigger is selected
   input  wire logic        filtered_external_trigger,  // external clear input
   input  wire logic [15:0] counter_value,              // running counter
   input  wire logic        count_down,                 // counter direction, 1 = down
   input  wire logic        update_event,               // update event pulse
   input  wire logic        trigger_edge,               // active trigger input edge
   output var  logic        ch1_compare_reference,      // channel 1 reference level
   output var  logic        ch2_compare_reference,      // channel 2 reference level
   output var  logic        ch1_capture_event,          // channel 1 capture pulse
   output var  logic        ch2_capture_event           // channel 2 capture pulse
);
   import tcm_pkg::*;

   typedef struct packed {
      logic [15:0]      mode;
      logic [1:0]       en;
      logic [1:0][15:0] cmp_shadow;
      logic [1:0][15:0] cmp_act;
      logic [1:0]       ref_lvl;
      logic [1:0]       prev_cmp;
      logic [1:0][2:0]  prev_func;
      logic [1:0]       trig_pipe;
      logic [1:0][2:0]  div_cnt;
      logic [1:0]       filt_prev;
      logic [1:0]       cap;
      logic [4:0]       samp_cnt;
      logic             ack;
      logic [31:0]      dat;
   } tcm_state_t;

   tcm_state_t st_reg;
   tcm_state_t st_next;

   logic [1:0] ti;
   logic [1:0] raw_in;
   logic [1:0] filt;

   assign ti = {timer_input_two, timer_input_one};

   // input mapping for each channel
   always_comb begin
      raw_in = 2'b00;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         case (st_reg.mode[ch*CH_STRIDE+SEL_LSB +: 2])
            DIR_OWN_INPUT:   raw_in[ch] = ti[ch];
            DIR_NEIGHBOUR:   raw_in[ch] = ti[1-ch];
            DIR_INT_TRIGGER: raw_in[ch] = internal_trigger_source
                                          & trigger_source_internal;
            default:         raw_in[ch] = 1'b0;
         endcase
      end
   end

   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_filt
         tcm_filter u_filt (
            .clk      (clk),
            .rst      (rst),
            .raw_in   (raw_in[g]),
            .code     (st_reg.mode[g*CH_STRIDE+FILT_LSB +: 4]),
            .div_cnt  (st_reg.samp_cnt),
            .filt_out (filt[g])
         );
      end
   endgenerate

   always_comb begin
      logic          req;
      logic [15:0]   wval;
      logic [15:0]   cmpv;
      logic [1:0]    dsel;
      logic [2:0]    func;
      logic          cmp_raw;
      logic          pwm_lvl;
      logic          is_pwm;
      logic          rise;
      logic [2:0]    div_top;
      logic [1:0]    div_code;
      logic [7:0]    ofs;
      req      = 1'b0;
      wval     = 16'h0000;
      cmpv     = 16'h0000;
      dsel     = 2'h0;
      func     = 3'h0;
      cmp_raw  = 1'b0;
      pwm_lvl  = 1'b0;
      is_pwm   = 1'b0;
      rise     = 1'b0;
      div_top  = 3'h0;
      div_code = 2'h0;
      ofs      = {wb_adr_i[7:2], 2'b00};

      st_next           = st_reg;
      st_next.ack       = 1'b0;
      st_next.cap       = 2'b00;
      st_next.samp_cnt  = st_reg.samp_cnt + 5'h01;
      st_next.trig_pipe = {st_reg.trig_pipe[0], trigger_edge};

      // per-channel compare and capture behaviour
      for (int ch = 0; ch < NUM_CH; ch++) begin
         dsel     = st_reg.mode[ch*CH_STRIDE+SEL_LSB +: 2];
         func     = st_reg.mode[ch*CH_STRIDE+FUNC_LSB +: 3];
         div_code = st_reg.mode[ch*CH_STRIDE+DIV_LSB +: 2];
         cmpv     = st_reg.cmp_act[ch];
         is_pwm   = (func == CMP_PWM1) || (func == CMP_PWM2);
         cmp_raw  = count_down ? !(counter_value > cmpv)
                               : (counter_value < cmpv);
         pwm_lvl  = (func == CMP_PWM2) ? !cmp_raw : cmp_raw;

         if (dsel == DIR_OUTPUT) begin
            // normal path follows counter and compare value
            case (func)
               CMP_FROZEN: begin
                  st_next.ref_lvl[ch] = st_reg.ref_lvl[ch];
               end
               CMP_SET_MATCH: begin
                  if (counter_value == cmpv) st_next.ref_lvl[ch] = 1'b1;
               end
               CMP_CLR_MATCH: begin
                  if (counter_value == cmpv) st_next.ref_lvl[ch] = 1'b0;
               end
               CMP_TOGGLE: begin
                  if (counter_value == cmpv) st_next.ref_lvl[ch] = !st_reg.ref_lvl[ch];
               end
               CMP_FORCE_LO: begin
                  st_next.ref_lvl[ch] = 1'b0;
               end
               CMP_FORCE_HI: begin
                  st_next.ref_lvl[ch] = 1'b1;
               end
               CMP_PWM1, CMP_PWM2: begin
                  if ((cmp_raw != st_reg.prev_cmp[ch]) ||
                      (st_reg.prev_func[ch] == CMP_FROZEN) ||
                      (st_reg.prev_func[ch] != func)) begin
                     st_next.ref_lvl[ch] = pwm_lvl;
                  end
               end
               default: begin
                  st_next.ref_lvl[ch] = st_reg.ref_lvl[ch];
               end
            endcase
            // trigger edge acts as a match, output level moves at the third edge
            if (st_reg.mode[ch*CH_STRIDE+FAST_BIT] && is_pwm
                && st_reg.trig_pipe[1]) begin
               st_next.ref_lvl[ch] = (func == CMP_PWM2);
            end
            if (st_reg.mode[ch*CH_STRIDE+CLEAR_BIT] && filtered_external_trigger) begin
               st_next.ref_lvl[ch] = 1'b0;
            end
            if (update_event && st_reg.mode[ch*CH_STRIDE+SHADOW_BIT]) begin
               st_next.cmp_act[ch] = st_reg.cmp_shadow[ch];
            end
            st_next.div_cnt[ch] = 3'h0;
         end else begin
            // capture path: rising edge of the filtered input
            rise    = filt[ch] && !st_reg.filt_prev[ch];
            div_top = {div_code == 2'h3, div_code >= 2'h2, div_code >= 2'h1};
            if (!st_reg.en[ch]) begin
               st_next.div_cnt[ch] = 3'h0;
            end else if (rise) begin
               if (st_reg.div_cnt[ch] == div_top) begin
                  st_next.div_cnt[ch]    = 3'h0;
                  st_next.cap[ch]        = 1'b1;
                  st_next.cmp_act[ch]    = counter_value;
                  st_next.cmp_shadow[ch] = counter_value;
               end else begin
                  st_next.div_cnt[ch] = st_reg.div_cnt[ch] + 3'h1;
               end
            end
         end
         st_next.filt_prev[ch] = filt[ch];
         st_next.prev_cmp[ch]  = cmp_raw;
         st_next.prev_func[ch] = func;
      end

      // wishbone classic slave, one wait state then ack for one cycle
      req = wb_cyc_i && wb_stb_i && !st_reg.ack;
      if (req) begin
         st_next.ack = 1'b1;
         st_next.dat = 32'h0000_0000;
         if (wb_we_i) begin
            case (ofs)
               OFS_MODE: begin
                  for (int ch = 0; ch < NUM_CH; ch++) begin
                     if (wb_sel_i[ch]) begin
                        // fields above the direction bits
                        st_next.mode[ch*CH_STRIDE+2 +: 6] =
                           wb_dat_i[ch*CH_STRIDE+2 +: 6];
                        if (!st_reg.en[ch]) begin
                           st_next.mode[ch*CH_STRIDE+SEL_LSB +: 2] =
                              wb_dat_i[ch*CH_STRIDE+SEL_LSB +: 2];
                        end
                     end
                  end
               end
               OFS_ENABLE: begin
                  if (wb_sel_i[0]) begin
                     st_next.en[0] = wb_dat_i[0];
                     st_next.en[1] = wb_dat_i[EN_STRIDE];
                  end
               end
               OFS_CMP1, OFS_CMP2: begin
                  for (int ch = 0; ch < NUM_CH; ch++) begin
                     if (ofs == ((ch == 0) ? OFS_CMP1 : OFS_CMP2)) begin
                        wval = st_reg.cmp_shadow[ch];
                        if (wb_sel_i[0]) wval[7:0] = wb_dat_i[7:0];
                        if (wb_sel_i[1]) wval[15:8] = wb_dat_i[15:8];
                        st_next.cmp_shadow[ch] = wval;
                        if (!st_reg.mode[ch*CH_STRIDE+SHADOW_BIT]) begin
                           st_next.cmp_act[ch] = wval;
                        end
                     end
                  end
               end
               default: begin
                  st_next.dat = 32'h0000_0000;
               end
            endcase
         end else begin
            case (ofs)
               OFS_MODE:   st_next.dat = {16'h0000, st_reg.mode};
               OFS_ENABLE: st_next.dat = {27'h0, st_reg.en[1], 3'h0, st_reg.en[0]};
               OFS_CMP1:   st_next.dat = {16'h0000, st_reg.cmp_shadow[0]};
               OFS_CMP2:   st_next.dat = {16'h0000, st_reg.cmp_shadow[1]};
               OFS_STATUS: begin
                  st_next.dat[ST_REF_LSB +: 2]  = st_reg.ref_lvl;
                  st_next.dat[ST_FILT_LSB +: 2] = filt;
                  st_next.dat[ST_CAP_LSB +: 2]  = st_reg.cap;
               end
               default:    st_next.dat = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg            <= '0;
         st_reg.mode       <= RST_MODE;
         st_reg.en         <= RST_ENABLE;
         st_reg.cmp_shadow <= {RST_CMP, RST_CMP};
         st_reg.cmp_act    <= {RST_CMP, RST_CMP};
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_o              = st_reg.dat;
   assign wb_ack_o              = st_reg.ack;
   assign ch1_compare_reference = st_reg.ref_lvl[0];
   assign ch2_compare_reference = st_reg.ref_lvl[1];
   assign ch1_capture_event     = st_reg.cap[0];
   assign ch2_capture_event     = st_reg.cap[1];

endmodule : tcm_top
`default_nettype wire

// *** tcm_pkg.sv ***
// constants and types shared by the timer channel mode control block
package tcm_pkg;

   // register byte offsets on the wishbone bus
   localparam logic [7:0]  OFS_MODE         = 8'h18;
   localparam logic [7:0]  OFS_ENABLE       = 8'h20;
   localparam logic [7:0]  OFS_CMP1         = 8'h34;
   localparam logic [7:0]  OFS_CMP2         = 8'h38;
   localparam logic [7:0]  OFS_STATUS       = 8'h3C;

   // reset values
   localparam logic [15:0] RST_MODE         = 16'h0000;
   localparam logic [1:0]  RST_ENABLE       = 2'h0;
   localparam logic [15:0] RST_CMP          = 16'h0000;

   // per-channel field layout inside the mode register
   localparam int          NUM_CH           = 2;
   localparam int          CH_STRIDE        = 8;
   localparam int          SEL_LSB          = 0;
   localparam int          FAST_BIT         = 2;
   localparam int          SHADOW_BIT       = 3;
   localparam int          FUNC_LSB         = 4;
   localparam int          CLEAR_BIT        = 7;
   localparam int          DIV_LSB          = 2;
   localparam int          FILT_LSB         = 4;

   // enable bit of channel n sits at n * EN_STRIDE in the enable register
   localparam int          EN_STRIDE        = 4;

   // status register bit positions
   localparam int          ST_REF_LSB       = 0;
   localparam int          ST_FILT_LSB      = 2;
   localparam int          ST_CAP_LSB       = 4;

   // trigger to output latency in clock cycles
   localparam int          FAST_TRIG_CYCLES = 3;
   localparam int          SLOW_TRIG_CYCLES = 5;

   // direction select codes
   localparam logic [1:0]  DIR_OUTPUT       = 2'h0;
   localparam logic [1:0]  DIR_OWN_INPUT    = 2'h1;
   localparam logic [1:0]  DIR_NEIGHBOUR    = 2'h2;
   localparam logic [1:0]  DIR_INT_TRIGGER  = 2'h3;

   typedef enum logic [2:0] {
      CMP_FROZEN    = 3'b000,
      CMP_SET_MATCH = 3'b001,
      CMP_CLR_MATCH = 3'b010,
      CMP_TOGGLE    = 3'b011,
      CMP_FORCE_LO  = 3'b100,
      CMP_FORCE_HI  = 3'b101,
      CMP_PWM1      = 3'b110,
      CMP_PWM2      = 3'b111
   } tcm_cmp_mode_t;

endpackage : tcm_pkg

// *** tcm_filter.sv ***
// digital input filter: an event counter with a selectable sampling rate
`timescale 1ns/1ns
`default_nettype none
module tcm_filter (
   input  wire logic       clk,        // timer kernel clock
   input  wire logic       rst,        // synchronous reset, active high
   input  wire logic       raw_in,     // mapped channel input
   input  wire logic [3:0] code,       // filter code of the channel
   input  wire logic [4:0] div_cnt,    // free-running sampling divider
   output var  logic       filt_out    // filtered level
);
   import tcm_pkg::*;

   typedef struct packed {
      logic [3:0] agree;
      logic       level;
   } tcm_filt_state_t;

   tcm_filt_state_t st_reg;
   tcm_filt_state_t st_next;

   logic [4:0] div_mask;
   logic [3:0] len;
   logic       tick;

   // sampling divider mask and filter length per code
   always_comb begin
      div_mask = 5'h00;
      len      = 4'h1;
      case (code)
         4'h0: begin div_mask = 5'h00; len = 4'h1; end
         4'h1: begin div_mask = 5'h00; len = 4'h2; end
         4'h2: begin div_mask = 5'h00; len = 4'h4; end
         4'h3: begin div_mask = 5'h00; len = 4'h8; end
         4'h4: begin div_mask = 5'h01; len = 4'h6; end
         4'h5: begin div_mask = 5'h01; len = 4'h8; end
         4'h6: begin div_mask = 5'h03; len = 4'h6; end
         4'h7: begin div_mask = 5'h03; len = 4'h8; end
         4'h8: begin div_mask = 5'h07; len = 4'h6; end
         4'h9: begin div_mask = 5'h07; len = 4'h8; end
         4'hA: begin div_mask = 5'h0F; len = 4'h5; end
         4'hB: begin div_mask = 5'h0F; len = 4'h6; end
         4'hC: begin div_mask = 5'h0F; len = 4'h8; end
         4'hD: begin div_mask = 5'h1F; len = 4'h5; end
         4'hE: begin div_mask = 5'h1F; len = 4'h6; end
         4'hF: begin div_mask = 5'h1F; len = 4'h8; end
         default: begin div_mask = 5'h00; len = 4'h1; end
      endcase
   end

   assign tick = ((div_cnt & div_mask) == 5'h00);

   always_comb begin
      st_next = st_reg;
      if (code == 4'h0) begin
         st_next.level = raw_in;
         st_next.agree = 4'h0;
      end else if (tick) begin
         if (raw_in == st_reg.level) begin
            st_next.agree = 4'h0;
         end else if (st_reg.agree == len - 4'h1) begin
            st_next.level = raw_in;
            st_next.agree = 4'h0;
         end else begin
            st_next.agree = st_reg.agree + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign filt_out = st_reg.level;

endmodule : tcm_filter
`default_nettype wire

// *** tcm_top_properties.sv ***
// port assertions for the timer channel mode control block
`timescale 1ns/1ns
`default_nettype none
module tcm_checker (
   input wire logic        clk,                       // clock
   input wire logic        rst,                       // reset
   input wire logic        wb_cyc_i,                  // cycle
   input wire logic        wb_stb_i,                  // strobe
   input wire logic        wb_we_i,                   // write
   input wire logic [7:0]  wb_adr_i,                  // address
   input wire logic [3:0]  wb_sel_i,                  // lanes
   input wire logic [31:0] wb_dat_i,                  // write data
   input wire logic [31:0] wb_dat_o,                  // read data
   input wire logic        wb_ack_o,                  // ack
   input wire logic        filtered_external_trigger, // clear input
   input wire logic        ch1_compare_reference,     // ref 1
   input wire logic        ch2_compare_reference,     // ref 2
   input wire logic        ch1_capture_event          // capture 1
);
   import tcm_pkg::*;
   logic [15:0] mode_q;
   logic [1:0]  en_q;
   logic        wr;
   logic        clr1;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign clr1 = mode_q[7] && filtered_external_trigger;
   // shadow of mode and enable, direction bits locked while enabled
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= RST_MODE;
         en_q   <= RST_ENABLE;
      end else if (wr && wb_adr_i[7:2] == OFS_MODE[7:2]) begin
         if (wb_sel_i[0]) mode_q[7:2] <= wb_dat_i[7:2];
         if (wb_sel_i[0] && !en_q[0]) mode_q[1:0] <= wb_dat_i[1:0];
         if (wb_sel_i[1]) mode_q[15:10] <= wb_dat_i[15:10];
         if (wb_sel_i[1] && !en_q[1]) mode_q[9:8] <= wb_dat_i[9:8];
      end else if (wr && wb_adr_i[7:2] == OFS_ENABLE[7:2] && wb_sel_i[0]) begin
         en_q <= {wb_dat_i[EN_STRIDE], wb_dat_i[0]};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_write_reads_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
      else $error("write ack carries data");
   a_unmapped_zero: assert property (wb_ack_o && !($past(wb_adr_i[7:2]) inside
      {6'h06, 6'h08, 6'h0D, 6'h0E, 6'h0F}) |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_mode_read_back: assert property (wb_ack_o && !$past(wb_we_i) &&
      $past(wb_adr_i[7:2]) == 6'h06 |-> wb_dat_o[15:0] == mode_q)
      else $error("mode register read mismatch");
   a_clear_forces_low: assert property (clr1 && mode_q[1:0] == 2'h0
      |=> !ch1_compare_reference)
      else $error("external clear ignored");
   a_force_level: assert property (!clr1 && mode_q[1:0] == 2'h0 &&
      mode_q[6:5] == 2'b10 |=> ch1_compare_reference == $past(mode_q[4]))
      else $error("forced level wrong on channel 1");
   a_ch2_force_level: assert property (!(mode_q[15] && filtered_external_trigger) &&
      mode_q[9:8] == 2'h0 && mode_q[14:13] == 2'b10
      |=> ch2_compare_reference == $past(mode_q[12]))
      else $error("forced level wrong on channel 2");
   a_frozen_holds: assert property (!clr1 && mode_q[6:4] == 3'h0 &&
      mode_q[1:0] == 2'h0 |=> $stable(ch1_compare_reference))
      else $error("frozen reference moved");
   a_no_capture_off: assert property (!en_q[0] [*3] |=> !ch1_capture_event)
      else $error("capture while disabled");
endmodule : tcm_checker
bind tcm_top tcm_checker u_tcm_checker (
   .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .filtered_external_trigger(filtered_external_trigger),
   .ch1_compare_reference(ch1_compare_reference),
   .ch2_compare_reference(ch2_compare_reference), .ch1_capture_event(ch1_capture_event)
);
`default_nettype wire

// *** tcm_pin_model.sv ***
// model of the timer input pins: bursts of square pulses on one pin
`timescale 1ns/1ns
`default_nettype none
module tcm_pin_model (
   input  wire logic       clk,   // kernel clock
   input  wire logic       start, // begin a burst
   input  wire logic [1:0] pin,   // 0 input one, 1 input two, 2 trigger
   input  wire logic [7:0] width, // cycles per phase
   input  wire logic [3:0] count, // rising edges per burst
   output var  logic [2:0] pins,  // pin levels
   output var  logic       busy   // burst running
);
   logic [7:0] t;
   logic [4:0] n;
   initial begin
      pins = 3'h0;
      busy = 1'b0;
   end
   always @(posedge clk) begin
      if (!busy) begin
         busy <= start;
         n    <= {count, 1'b0};
         t    <= width;
      end else if (t > 8'h01) begin
         t <= t - 8'h01;
      end else begin
         pins[pin] <= ~pins[pin];
         t         <= width;
         n         <= n - 5'h01;
         busy      <= (n > 5'h01);
      end
   end
endmodule : tcm_pin_model
`default_nettype wire

// *** test_timer_channel_mode_control.sv ***
// self-checking bench for the timer channel mode control block
`timescale 1ns/1ns
`default_nettype none
module test_timer_channel_mode_control;
   import tcm_pkg::*;
   logic        clk, rst, cyc, stb, we, ack, tsi, etr, dn, upd, trig;
   logic        ref1, ref2, cap1, cap2, m_start, busy;
   logic [1:0]  m_pin;
   logic [2:0]  pins;
   logic [3:0]  sel, m_count;
   logic [7:0]  adr, m_width;
   logic [15:0] cnt, q;
   logic [31:0] dat, dat_o;
   int          fail_count, tests_run, cycles, c1, c2, i, k;
   logic [2:0]  m_init [4] = '{3'h4, 3'h5, 3'h4, 3'h5};
   logic [2:0]  m_tgt [4] = '{3'h1, 3'h2, 3'h3, 3'h0};
   logic        m_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   logic [15:0] p_cnt [4] = '{16'h000F, 16'h0010, 16'h0011, 16'h0010};
   logic        p_dn [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   logic        p_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   logic [15:0] q_mode [3] = '{16'h0060, 16'h0054, 16'h0064};
   logic        q_exp [3] = '{1'b1, 1'b1, 1'b0};
   logic [1:0]  pin_of [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h2};
   logic [3:0]  f_code [8] = '{4'h1, 4'h1, 4'h3, 4'h3, 4'h5, 4'h5, 4'hD, 4'hD};
   logic [7:0]  f_w [8] = '{8'h01, 8'h04, 8'h06, 8'h0C, 8'h0C, 8'h18, 8'h64, 8'hC8};
   tcm_top u_tcm_top (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .timer_input_one(pins[0]), .timer_input_two(pins[1]), .internal_trigger_source(pins[2]),
      .trigger_source_internal(tsi), .filtered_external_trigger(etr), .counter_value(cnt),
      .count_down(dn), .update_event(upd), .trigger_edge(trig), .ch1_compare_reference(ref1),
      .ch2_compare_reference(ref2), .ch1_capture_event(cap1), .ch2_capture_event(cap2));
   tcm_pin_model u_tcm_pin_model (.clk(clk), .start(m_start), .pin(m_pin), .width(m_width),
      .count(m_count), .pins(pins), .busy(busy));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      c1 = c1 + (cap1 === 1'b1);
      c2 = c2 + (cap2 === 1'b1);
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         final_report();
      end
   end
   task final_report();
      $display("checks=%0d errors=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   task chk16(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk16
   task chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask : chk1
   task step(input int n);
      repeat (n) @(posedge clk);
   endtask : step
   // one classic cycle: hold everything until ack is sampled
   task wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= s;
      dat <= {16'h0000, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_o[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb
   task wr(input logic [7:0] a, input logic [15:0] d);
      wb(1'b1, a, d, 4'h3);
   endtask : wr
   task rdchk(input logic [7:0] a, input logic [15:0] e);
      wb(1'b0, a, 16'h0000, 4'h3);
      chk16(q, e);
   endtask : rdchk
   task burst(input logic [1:0] p, input logic [7:0] w, input logic [3:0] c);
      m_pin   <= p;
      m_width <= w;
      m_count <= c;
      m_start <= 1'b1;
      @(posedge clk);
      m_start <= 1'b0;
      do begin
         @(posedge clk);
      end while (busy !== 1'b0);
      step(300);
   endtask : burst
   initial begin
      {clk, cyc, stb, we, tsi, etr, dn, upd, trig, m_start, m_pin} = '0;
      {adr, sel, dat, cnt, m_width, m_count} = '0;
      rst = 1'b1;
      step(16);
      rst <= 1'b0;
      step(1);
      rdchk(OFS_MODE, RST_MODE);
      rdchk(OFS_ENABLE, 16'h0000);
      wr(8'h44, 16'hFFFF);
      rdchk(8'h44, 16'h0000);
      wr(OFS_MODE, 16'hFFFC);
      rdchk(OFS_MODE, 16'hFFFC);
      wb(1'b1, OFS_MODE, 16'h1234, 4'h1);
      rdchk(OFS_MODE, 16'hFF34);
      wr(OFS_MODE, 16'h0101);
      wr(OFS_ENABLE, 16'h0011);
      wr(OFS_MODE, 16'h02F2);
      rdchk(OFS_MODE, 16'h01F1);
      wr(OFS_ENABLE, 16'h0000);
      wr(OFS_MODE, 16'h5050);
      step(2);
      chk1(ref1, 1'b1);
      chk1(ref2, 1'b1);
      rdchk(OFS_STATUS, 16'h0003);
      wr(OFS_MODE, 16'h00D0);
      etr <= 1'b1;
      step(3);
      chk1(ref1, 1'b0);
      wr(OFS_MODE, 16'h0050);
      step(3);
      chk1(ref1, 1'b1);
      etr <= 1'b0;
      wr(OFS_CMP1, 16'h0010);
      wr(OFS_CMP2, 16'h0010);
      for (i = 0; i < 4; i++) begin
         wr(OFS_MODE, {1'b0, m_init[i], 4'h0, 1'b0, m_init[i], 4'h0});
         wr(OFS_MODE, {1'b0, m_tgt[i], 4'h0, 1'b0, m_tgt[i], 4'h0});
         cnt <= 16'h0010;
         step(1);
         cnt <= 16'h0000;
         step(3);
         chk1(ref1, m_exp[i]);
         chk1(ref2, m_exp[i]);
      end
      for (k = 6; k < 8; k++) begin
         wr(OFS_MODE, {1'b0, k[2:0], 4'h0, 1'b0, k[2:0], 4'h0});
         for (i = 0; i < 4; i++) begin
            cnt <= p_cnt[i];
            dn  <= p_dn[i];
            step(3);
            chk1(ref1, p_exp[i] ^ (k == 7));
            chk1(ref2, p_exp[i] ^ (k == 7));
         end
      end
      cnt <= 16'h000F;
      dn  <= 1'b0;
      // shadowed compare value waits for the update event
      wr(OFS_MODE, 16'h0068);
      wr(OFS_CMP1, 16'h0008);
      rdchk(OFS_CMP1, 16'h0008);
      step(3);
      chk1(ref1, 1'b1);
      upd <= 1'b1;
      step(1);
      upd <= 1'b0;
      step(3);
      chk1(ref1, 1'b0);
      wr(OFS_MODE, 16'h0060);
      wr(OFS_CMP1, 16'h0010);
      step(3);
      chk1(ref1, 1'b1);
      for (i = 0; i < 3; i++) begin
         wr(OFS_MODE, q_mode[i]);
         step(3);
         trig <= 1'b1;
         step(1);
         trig <= 1'b0;
         step(2);
         chk1(ref1, 1'b1);
         step(1);
         chk1(ref1, q_exp[i]);
      end
      tsi <= 1'b1;
      for (i = 0; i < 6; i++) begin
         k = i % 3 + 1;
         wr(OFS_MODE, (i < 3) ? {14'h0000, k[1:0]} : {6'h00, k[1:0], 8'h00});
         wr(OFS_ENABLE, (i < 3) ? 16'h0001 : 16'h0010);
         c1 = 0;
         c2 = 0;
         burst(pin_of[i], 8'h04, 4'h3);
         chk16(16'(c1 + c2), 16'h0003);
         rdchk((i < 3) ? OFS_CMP1 : OFS_CMP2, 16'h000F);
         wr(OFS_ENABLE, 16'h0000);
      end
      for (i = 1; i < 4; i++) begin
         wr(OFS_MODE, {12'h000, i[1:0], 2'b01});
         wr(OFS_ENABLE, 16'h0001);
         c1 = 0;
         burst(2'h0, 8'h04, 4'h8);
         chk16(16'(c1), 16'(8 >> i));
         wr(OFS_ENABLE, 16'h0000);
      end
      wr(OFS_MODE, 16'h0005);
      wr(OFS_ENABLE, 16'h0001);
      c1 = 0;
      burst(2'h0, 8'h04, 4'h1);
      wr(OFS_ENABLE, 16'h0000);
      wr(OFS_ENABLE, 16'h0001);
      burst(2'h0, 8'h04, 4'h1);
      chk16(16'(c1), 16'h0000);
      burst(2'h0, 8'h04, 4'h1);
      chk16(16'(c1), 16'h0001);
      for (i = 0; i < 8; i++) begin
         wr(OFS_MODE, {8'h00, f_code[i], 4'h1});
         c1 = 0;
         burst(2'h0, f_w[i], 4'h2);
         chk16(16'(c1), 16'((i % 2) * 2));
      end
      final_report();
   end
endmodule : test_timer_channel_mode_control
`default_nettype wire
